/* src/tcml_channel_logic.sv */
// two-channel capture/compare mode logic with shared 16-bit counter
// assumes synchronous inputs, one clock, plain strobe register port
//
// Functional notes
// - both edge bits zero frees the pin
// - preset level from compare_mode_sel, inverted
// - capture mode edge select rising/falling/both
// - unbuffered compare: none, toggle, clear, set
// - buffered compare actions regardless of mode A
// - toggle pin on overflow in compare modes
// - overflow action beats coinciding compare
// - max duty forces full duty with toggle
// - max duty change applies next period
// - full duty level follows polarity bit
// - value registers hold capture or compare
// - high read blocks capture until low read
// - high write blocks compare until low write
// - flag on capture edge or compare match
// - channel 0 buffered disables channel 1
// - overflow at modulo, restart from zero
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "tcml_defines.svh"

module tcml_channel_logic (
    input  wire logic       clk_in,      // 20 MHz timer clock
    input  wire logic       arst_n_in,   // async reset, active low
    input  wire logic [3:0] addr_in,     // register byte address
    input  wire logic [7:0] wdata_in,    // write data
    input  wire logic       wr_in,       // write strobe
    input  wire logic       rd_in,       // read strobe
    input  wire logic [1:0] cap_in,      // channel pin input levels
    output logic      [7:0] rdata_out,   // read data, cycle after strobe
    output logic      [1:0] pin_out,     // channel pin output level
    output logic      [1:0] pin_oe_out,  // high while timer drives pin
    output logic            ovf_out,     // counter overflow pulse
    output logic            irq_out      // level interrupt
);

    // -----------------------------------------------------------------------
    // state
    // -----------------------------------------------------------------------
    tcml_pkg::tcml_state_t st_r;   // registered state
    tcml_pkg::tcml_state_t st_nxt; // next state

    // decoded per-channel mode, combinational
    tcml_pkg::tcml_mode_t  mode [2];
    logic [1:0]            edge_hit;
    logic [1:0]            match;
    logic [1:0]            disabled;
    logic                  ovf;

    // -----------------------------------------------------------------------
    // mode decode per channel
    // -----------------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_dec
        logic [1:0] sel;
        logic       rise;
        logic       fall;
        logic [15:0] cmp_val;
        logic        sw_cmp;
        assign sel  = {st_r.ctrl[c][`TCML_B_ELS_HI], st_r.ctrl[c][`TCML_B_ELS_LO]};
        assign disabled[c] = (c == 1) && st_r.ctrl[0][`TCML_B_MSB];
        always_comb begin
            if (disabled[c] || sel == 2'b00) begin
                mode[c] = tcml_pkg::TCML_PRESET;
            end else if (st_r.ctrl[c][`TCML_B_MSB]) begin
                mode[c] = tcml_pkg::TCML_CMP_BUF;
            end else if (st_r.ctrl[c][`TCML_B_MSA]) begin
                mode[c] = tcml_pkg::TCML_CMP_UNBUF;
            end else begin
                mode[c] = tcml_pkg::TCML_CAPTURE;
            end
        end
        assign rise = cap_in[c] & ~st_r.cap_prev[c];
        assign fall = ~cap_in[c] & st_r.cap_prev[c];
        assign edge_hit[c] = (mode[c] == tcml_pkg::TCML_CAPTURE)
                           && ((sel[0] && rise) || (sel[1] && fall));
        // buffered mode compares against the active register
        assign cmp_val = (mode[c] == tcml_pkg::TCML_CMP_BUF) ? st_r.val[st_r.buf_sel] : st_r.val[c];
        // software compare only, flag without pin action
        assign sw_cmp = (sel == 2'b00) && !disabled[c]
                      && st_r.ctrl[c][`TCML_B_MSA] && !st_r.ctrl[c][`TCML_B_MSB];
        // compare blocked while high byte pending
        assign match[c] = (mode[c] == tcml_pkg::TCML_CMP_UNBUF || mode[c] == tcml_pkg::TCML_CMP_BUF || sw_cmp)
                        && !st_r.cmp_lock[c] && st_r.run && (st_r.cnt == cmp_val);
    end

    assign ovf = st_r.run && (st_r.cnt == st_r.modv);

    // -----------------------------------------------------------------------
    // next-state logic
    // -----------------------------------------------------------------------
    always_comb begin
        logic [1:0]  sel;
        logic        cmp_mode;
        logic        full;
        logic [7:0]  w;
        logic [2:0]  ev;
        sel      = 2'b00;
        cmp_mode = 1'b0;
        full     = 1'b0;
        w        = wdata_in;
        ev       = 3'h0;
        st_nxt   = st_r;
        st_nxt.cap_prev = cap_in;
        st_nxt.rdata    = 8'h00;
        st_nxt.ovf      = ovf;

        // counter with clear and run controls
        if (ovf) begin
            st_nxt.cnt = 16'h0000;
        end else if (st_r.run) begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end
        if (ovf && st_r.ctrl[0][`TCML_B_MSB]) begin
            st_nxt.buf_sel = ~st_r.buf_sel;
        end

        for (int c = 0; c < 2; c++) begin
            sel = {st_r.ctrl[c][`TCML_B_ELS_HI], st_r.ctrl[c][`TCML_B_ELS_LO]};
            cmp_mode = (mode[c] == tcml_pkg::TCML_CMP_UNBUF) || (mode[c] == tcml_pkg::TCML_CMP_BUF);
            // max duty sampled once per period
            if (ovf) begin
                st_nxt.max_act[c] = st_r.ctrl[c][`TCML_B_MAX] & st_r.ctrl[c][`TCML_B_TOV];
            end
            full = st_r.ctrl[c][`TCML_B_POL];
            if (mode[c] == tcml_pkg::TCML_PRESET) begin
                // preset level, high when mode A clear
                st_nxt.pin[c] = ~st_r.ctrl[c][`TCML_B_MSA];
            end else if (cmp_mode && st_r.max_act[c]) begin
                st_nxt.pin[c] = full;
            end else if (cmp_mode && ovf && st_r.ctrl[c][`TCML_B_TOV]) begin
                st_nxt.pin[c] = ~st_r.pin[c];
            end else if (match[c]) begin
                unique case (sel)
                    2'b01:   st_nxt.pin[c] = ~st_r.pin[c];
                    2'b10:   st_nxt.pin[c] = 1'b0;
                    2'b11:   st_nxt.pin[c] = 1'b1;
                    default: st_nxt.pin[c] = st_r.pin[c];
                endcase
            end
            st_nxt.oe[c] = cmp_mode;
            if (edge_hit[c] && !st_r.cap_lock[c]) begin
                st_nxt.val[c] = st_r.cnt;
            end
            if ((edge_hit[c] && !st_r.cap_lock[c]) || match[c]) begin
                ev[c] = 1'b1;
            end
        end
        ev[2] = ovf;

        // register reads
        if (rd_in) begin
            for (int c = 0; c < 2; c++) begin
                if (addr_in == `TCML_OFS_CTRL0 + 4'(3 * c)) begin
                    st_nxt.rdata = disabled[c] ? 8'h00 : st_r.ctrl[c];
                    st_nxt.flag_armed[c] = st_r.ctrl[c][`TCML_B_FLAG];
                end
                if (addr_in == `TCML_OFS_HIGH0 + 4'(3 * c)) begin
                    st_nxt.rdata = st_r.val[c][15:8];
                    if (mode[c] == tcml_pkg::TCML_CAPTURE) begin
                        st_nxt.cap_lock[c]  = 1'b1;
                        st_nxt.low_latch[c] = st_r.val[c][7:0];
                    end
                end
                if (addr_in == `TCML_OFS_LOW0 + 4'(3 * c)) begin
                    st_nxt.rdata = st_r.cap_lock[c] ? st_r.low_latch[c] : st_r.val[c][7:0];
                    st_nxt.cap_lock[c] = 1'b0;
                end
            end
            unique case (addr_in)
                `TCML_OFS_MOD_HIGH: st_nxt.rdata = st_r.modv[15:8];
                `TCML_OFS_MOD_LOW:  st_nxt.rdata = st_r.modv[7:0];
                `TCML_OFS_TCTRL:    st_nxt.rdata = {7'h00, st_r.run};
                `TCML_OFS_IRQ_STAT: st_nxt.rdata = {5'h00, st_r.irq_stat};
                `TCML_OFS_IRQ_MASK: st_nxt.rdata = {5'h00, st_r.irq_mask};
                `TCML_OFS_PIN_STAT: st_nxt.rdata = {4'h0, st_r.oe, st_r.pin};
                default: ;
            endcase
        end

        // register writes
        if (wr_in) begin
            for (int c = 0; c < 2; c++) begin
                if (addr_in == `TCML_OFS_CTRL0 + 4'(3 * c) && !disabled[c]) begin
                    st_nxt.ctrl[c][6:0] = w[6:0];
                    if (c == 1) begin
                        st_nxt.ctrl[c][`TCML_B_MSB] = 1'b0;
                    end
                    // flag clears only by write 0 after armed read
                    if (!w[`TCML_B_FLAG] && st_r.flag_armed[c]) begin
                        st_nxt.ctrl[c][`TCML_B_FLAG] = 1'b0;
                    end
                    st_nxt.flag_armed[c] = 1'b0;
                end
                if (addr_in == `TCML_OFS_HIGH0 + 4'(3 * c)) begin
                    st_nxt.hi_buf[c] = w;
                    st_nxt.cmp_lock[c] = (mode[c] != tcml_pkg::TCML_CAPTURE);
                end
                if (addr_in == `TCML_OFS_LOW0 + 4'(3 * c)) begin
                    st_nxt.val[c] = {st_r.cmp_lock[c] ? st_r.hi_buf[c] : st_r.val[c][15:8], w};
                    st_nxt.cmp_lock[c] = 1'b0;
                end
            end
            unique case (addr_in)
                `TCML_OFS_MOD_HIGH: st_nxt.mod_hi = w;
                `TCML_OFS_MOD_LOW:  st_nxt.modv = {st_r.mod_hi, w};
                `TCML_OFS_TCTRL: begin
                    st_nxt.run = w[`TCML_B_RUN];
                    if (w[`TCML_B_CLR]) begin
                        st_nxt.cnt = 16'h0000;
                    end
                end
                `TCML_OFS_IRQ_STAT: st_nxt.irq_stat = st_r.irq_stat & ~w[2:0];
                `TCML_OFS_IRQ_MASK: st_nxt.irq_mask = w[2:0];
                default: ;
            endcase
        end

        // events set after clears so a set wins
        for (int c = 0; c < 2; c++) begin
            if (ev[c]) begin
                st_nxt.ctrl[c][`TCML_B_FLAG] = 1'b1;
                st_nxt.flag_armed[c] = 1'b0;
            end
        end
        st_nxt.irq_stat = st_nxt.irq_stat | ev;
        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
    end

    // -----------------------------------------------------------------------
    // state register; value contents left zeroed though undefined
    // -----------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_r          <= '0;
            st_r.modv     <= `TCML_RST_MOD;
            st_r.pin      <= 2'b11;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_out  = st_r.rdata;
    assign pin_out    = st_r.pin;
    assign pin_oe_out = st_r.oe;
    assign ovf_out    = st_r.ovf;
    assign irq_out    = st_r.irq;

    // -----------------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    a_preset_release: assert property (mode[0] == tcml_pkg::TCML_PRESET |=> !pin_oe_out[0])
        else $error("pin driven in preset");
    a_preset_level: assert property (mode[0] == tcml_pkg::TCML_PRESET |=> pin_out[0] == ~$past(st_r.ctrl[0][4]))
        else $error("preset level wrong");
    a_capture_copy: assert property (edge_hit[0] && !st_r.cap_lock[0] && !wr_in |=> st_r.val[0] == $past(st_r.cnt))
        else $error("capture missed");
    a_capture_block: assert property (st_r.cap_lock[0] && !wr_in |=> st_r.val[0] == $past(st_r.val[0]))
        else $error("capture while blocked");
    a_compare_block: assert property (st_r.cmp_lock[1] |-> !match[1])
        else $error("compare while blocked");
    a_ovf_wins: assert property (ovf && st_r.ctrl[0][1] && match[0] && !st_r.max_act[0]
                                 && mode[0] != tcml_pkg::TCML_PRESET |=> pin_out[0] != $past(pin_out[0]))
        else $error("overflow lost to compare");
    a_flag_set: assert property (match[0] |=> st_r.ctrl[0][7])
        else $error("flag not set");
    a_chan1_off: assert property (st_r.ctrl[0][5] |-> mode[1] == tcml_pkg::TCML_PRESET)
        else $error("channel 1 active in buffered");
    a_cnt_wrap: assert property (ovf && !wr_in |=> st_r.cnt == 16'h0000)
        else $error("counter no wrap");
    a_full_duty: assert property (st_r.max_act[0] && (mode[0] == tcml_pkg::TCML_CMP_UNBUF
                                  || mode[0] == tcml_pkg::TCML_CMP_BUF) |=> pin_out[0] == $past(st_r.ctrl[0][6]))
        else $error("full duty level wrong");

    c_capture: cover property (edge_hit[0] && !st_r.cap_lock[0]);
    c_match: cover property (match[0]);
    c_buffered_swap: cover property (ovf && st_r.ctrl[0][5]);
    c_max_duty: cover property (st_r.max_act[1]);

endmodule

/* src/tcml_defines.svh */
// register offsets, field positions and reset values of the timer channel block
// assumes inclusion by bare name from the src folder
`ifndef TCML_DEFINES_SVH
`define TCML_DEFINES_SVH

// ---------------------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------------------
`define TCML_OFS_CTRL0     4'h0
`define TCML_OFS_HIGH0     4'h1
`define TCML_OFS_LOW0      4'h2
`define TCML_OFS_CTRL1     4'h3
`define TCML_OFS_HIGH1     4'h4
`define TCML_OFS_LOW1      4'h5
`define TCML_OFS_MOD_HIGH  4'h6
`define TCML_OFS_MOD_LOW   4'h7
`define TCML_OFS_TCTRL     4'h8
`define TCML_OFS_IRQ_STAT  4'h9
`define TCML_OFS_IRQ_MASK  4'ha
`define TCML_OFS_PIN_STAT  4'hb

// ---------------------------------------------------------------------------
// channel control/status field positions
// ---------------------------------------------------------------------------
`define TCML_B_MAX    0
`define TCML_B_TOV    1
`define TCML_B_ELS_LO 2
`define TCML_B_ELS_HI 3
`define TCML_B_MSA    4
`define TCML_B_MSB    5
`define TCML_B_POL    6
`define TCML_B_FLAG   7

// timer control: bit 0 runs the counter, bit 1 clears it
`define TCML_B_RUN    0
`define TCML_B_CLR    1

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define TCML_RST_CTRL 8'h00
`define TCML_RST_MOD  16'hffff
`define TCML_RST_IRQ  3'h0

`endif

/* src/tcml_pkg.sv */
// types shared by the timer channel block
// assumes the defines header sits beside it
package tcml_pkg;

    // decoded channel operating mode
    typedef enum logic [2:0] {
        TCML_PRESET,
        TCML_CAPTURE,
        TCML_CMP_UNBUF,
        TCML_CMP_BUF
    } tcml_mode_t;

    // all state of the block
    typedef struct packed {
        logic [1:0][7:0]  ctrl;      // channel control/status bytes
        logic [1:0][15:0] val;       // channel value registers
        logic [1:0][7:0]  hi_buf;    // staged high byte of a write
        logic [1:0]       cap_lock;  // captures blocked until low read
        logic [1:0][7:0]  low_latch; // low byte frozen by high read
        logic [1:0]       cmp_lock;  // compares blocked until low write
        logic [1:0]       flag_armed;// control read with flag set seen
        logic [1:0]       pin;       // channel pin drive level
        logic [1:0]       max_act;   // full duty active this period
        logic [1:0]       cap_prev;  // last sampled capture input
        logic [15:0]      cnt;       // shared counter
        logic [15:0]      modv;      // modulo value
        logic [7:0]       mod_hi;    // staged modulo high byte
        logic             run;       // counter running
        logic             buf_sel;   // which channel register is active
        logic [2:0]       irq_stat;  // ch0, ch1, overflow sticky events
        logic [2:0]       irq_mask;  // interrupt mask
        logic             irq;       // interrupt output
        logic [7:0]       rdata;     // read data
        logic [1:0]       oe;        // pin enables
        logic             ovf;       // overflow pulse out
    } tcml_state_t;

endpackage

/* test/tcml_channel_logic_tb.sv */
// self-checking bench of the timer channel block
// assumes the pin model beside it and the design under src
`timescale 1ns/1ps

module tcml_channel_logic_tb;
    logic       clk_in, arst_n_in, wr_in, rd_in, ovf_out, irq_out; // control lines
    logic [3:0] addr_in;                                           // register address
    logic [7:0] wdata_in, rdata_out, v, w;                         // bus data, scratch
    logic [1:0] cap_in, pin_out, pin_oe_out;                       // pin side
    int         error_cnt, cmp_count, n, e;                        // counters

    tcml_channel_logic i_tcml_channel_logic (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .cap_in(cap_in), .rdata_out(rdata_out), .pin_out(pin_out),
        .pin_oe_out(pin_oe_out), .ovf_out(ovf_out), .irq_out(irq_out));
    tcml_pin_model i_tcml_pin_model (.clk_in(clk_in), .pin_out_in(pin_out),
        .pin_oe_in(pin_oe_out), .cap_out(cap_in));

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic stop_test();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask

    // bounded wait for a high level on irq (sel 0) or ovf (sel 1)
    task automatic wait_hi(input int sel, output int cyc);
        for (cyc = 1; cyc < 300; cyc++) begin
            @(posedge clk_in);
            #1;
            if ((sel == 0 ? irq_out : ovf_out) === 1'b1) begin
                return;
            end
        end
        $display("unexpected timeout expected 1 seen 0");
        error_cnt++;
        stop_test();
    endtask

    task automatic edge_cap(input logic lvl);
        i_tcml_pin_model.set_level(0, lvl);
        repeat (3) @(posedge clk_in);
    endtask

    // channel 0 flag clearing: read with flag set, then write bit7 low
    task automatic clr_flag(input logic [7:0] c);
        rd(4'h0, v);
        wr(4'h0, c);
        wr(4'h9, 8'h01);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rd(4'h0, v); chk("ctrl0", 8'h00, v);
        rd(4'hc, v); chk("unmapped", 8'h00, v);
        chk("oe", 8'h00, {6'h0, pin_oe_out});
        wr(4'h0, 8'h10); repeat (2) @(posedge clk_in);
        chk("preset oe", 8'h00, {7'h0, pin_oe_out[0]});
        chk("preset low", 8'h00, {7'h0, pin_out[0]});
        wr(4'h0, 8'h00); repeat (2) @(posedge clk_in);
        chk("preset high", 8'h01, {7'h0, pin_out[0]});
    endtask

    // every edge select with both edges applied
    task automatic t_capture();
        for (int s = 1; s < 4; s++) begin
            w = 8'(s << 2);
            wr(4'h0, w);
            clr_flag(w);
            edge_cap(1'b1);
            rd(4'h0, v); chk("rise flag", 8'(s & 1), {7'h0, v[7]});
            clr_flag(w);
            edge_cap(1'b0);
            rd(4'h0, v); chk("fall flag", 8'(s >> 1), {7'h0, v[7]});
            clr_flag(w);
        end
    endtask

    task automatic t_cap_lock();
        logic [7:0] h1, l1;
        edge_cap(1'b1);
        edge_cap(1'b0);
        rd(4'h1, h1); rd(4'h2, l1);
        chk("cap high", 8'h00, h1);
        chk("cap range", 8'h01, {7'h0, l1 <= 8'h40});
        rd(4'h1, v);
        repeat (100) @(posedge clk_in);
        edge_cap(1'b1);
        rd(4'h2, v); chk("frozen low", l1, v);
        rd(4'h1, v); chk("held high", h1, v);
        rd(4'h2, v); chk("held low", l1, v);
        edge_cap(1'b0);
    endtask

    // compare actions: toggle, clear, set, none
    task automatic t_compare();
        logic b;
        wr(4'h1, 8'h00); wr(4'h2, 8'h10);
        for (int k = 0; k < 4; k++) begin
            w = 8'h10 | 8'(((k + 1) % 4) << 2);
            wr(4'h0, w); wr(4'h9, 8'h01);
            wait_hi(0, n); wr(4'h9, 8'h01);
            b = pin_out[0];
            wait_hi(0, n); wr(4'h9, 8'h01);
            case (k)
                0: chk("toggle", {7'h0, ~b}, {7'h0, pin_out[0]});
                1: chk("clear", 8'h00, {7'h0, pin_out[0]});
                2: chk("set", 8'h01, {7'h0, pin_out[0]});
                default: chk("sw only oe", 8'h00, {7'h0, pin_oe_out[0]});
            endcase
        end
    endtask

    task automatic t_hi_lock();
        wr(4'h0, 8'h1c); wr(4'h1, 8'h00); wr(4'h9, 8'h01);
        repeat (150) @(posedge clk_in);
        chk("blocked irq", 8'h00, {7'h0, irq_out});
        wr(4'h2, 8'h10);
        wait_hi(0, n);
        wr(4'ha, 8'h00); #1;
        chk("masked irq", 8'h00, {7'h0, irq_out});
        wr(4'ha, 8'h01); #1;
        chk("unmasked irq", 8'h01, {7'h0, irq_out});
        wr(4'h9, 8'h01); #1;
        chk("cleared irq", 8'h00, {7'h0, irq_out});
    endtask

    // compare at the modulo value: overflow toggle alone wins
    task automatic t_tov();
        wr(4'h1, 8'h00); wr(4'h2, 8'h40); wr(4'h0, 8'h16);
        wait_hi(1, n); wait_hi(1, n);
        chk("period", 8'd65, 8'(n));
        e = i_tcml_pin_model.edge_cnt[0];
        repeat (4) wait_hi(1, n);
        chk("ovf toggles", 8'd4, 8'(i_tcml_pin_model.edge_cnt[0] - e));
    endtask

    task automatic t_max();
        wr(4'h2, 8'h10);
        for (int p = 0; p < 2; p++) begin
            wr(4'h0, p ? 8'h5b : 8'h1b);
            wait_hi(1, n); wait_hi(1, n);
            e = i_tcml_pin_model.edge_cnt[0];
            wait_hi(1, n); wait_hi(1, n);
            chk("full level", 8'(p), {7'h0, pin_out[0]});
            chk("full steady", 8'h00, 8'(i_tcml_pin_model.edge_cnt[0] - e));
        end
        wr(4'h0, 8'h5a);
        wait_hi(1, n); wait_hi(1, n);
        e = i_tcml_pin_model.edge_cnt[0];
        wait_hi(1, n);
        chk("duty back", 8'h02, 8'(i_tcml_pin_model.edge_cnt[0] - e));
    endtask

    task automatic t_buffer();
        logic b;
        wr(4'h3, 8'h14); rd(4'h3, v); chk("ctrl1", 8'h14, v);
        wr(4'h4, 8'h00); wr(4'h5, 8'h10);
        wr(4'h0, 8'h24); rd(4'h3, v); chk("ctrl1 off", 8'h00, v);
        wr(4'h3, 8'h18); rd(4'h3, v); chk("ctrl1 lock", 8'h00, v);
        chk("oe1", 8'h00, {7'h0, pin_oe_out[1]});
        wr(4'h9, 8'h01); wait_hi(0, n); wr(4'h9, 8'h01);
        b = pin_out[0];
        wait_hi(0, n);
        repeat (2) @(posedge clk_in);
        chk("buf toggle", {7'h0, ~b}, {7'h0, pin_out[0]});
        chk("buf oe", 8'h01, {7'h0, pin_oe_out[0]});
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {wr_in, rd_in, addr_in, wdata_in} = '0;
        error_cnt = 0;
        cmp_count = 0;
        arst_n_in = 1'b0;
        repeat (8) @(posedge clk_in);
        arst_n_in <= 1'b1;
        t_reset();
        wr(4'h6, 8'h00); wr(4'h7, 8'h40); wr(4'h8, 8'h03); wr(4'ha, 8'h01);
        t_capture();
        t_cap_lock();
        t_compare();
        t_hi_lock();
        t_tov();
        t_max();
        t_buffer();
        stop_test();
    end
endmodule

/* test/tcml_pin_model.sv */
// pin-side model: capture sources and a watcher of the driven pins
// assumes one clock shared with the channel block
`timescale 1ns/1ps

module tcml_pin_model (
    input  wire logic       clk_in,     // timer clock
    input  wire logic [1:0] pin_out_in, // pin level driven by the block
    input  wire logic [1:0] pin_oe_in,  // pin enables of the block
    output logic      [1:0] cap_out     // levels seen at capture inputs
);
    int unsigned edge_cnt [2]; // driven pin changes seen
    logic [1:0]  pin_prev;     // last sampled pin level

    initial begin
        cap_out = 2'h0;
        pin_prev = 2'h3;
        edge_cnt = '{0, 0};
    end

    // count changes only while driven; an undriven pin says nothing
    always @(posedge clk_in) begin
        for (int i = 0; i < 2; i++) begin
            if (pin_oe_in[i] === 1'b1 && pin_out_in[i] !== pin_prev[i]) begin
                edge_cnt[i]++;
            end
        end
        pin_prev <= pin_out_in;
    end

    // one level change on a capture input, just after an edge
    task automatic set_level(input int ch, input logic lvl);
        @(posedge clk_in);
        cap_out[ch] <= lvl;
    endtask
endmodule
